// ---- spi_flash_pkg.sv ----
// Shared constants and types for the serial flash read link
package spi_flash_pkg;
	localparam int CMD_BITS = 8;
	localparam int ADDR_BITS = 24;
	localparam int DUMMY_BITS = 8;
	localparam int MAX_ADDR_W = 22;
	localparam int SECTOR_SHIFT = 16;
	localparam int OTP_BYTES = 65;
	localparam int OTP_AW = 7;
	localparam logic [6:0] OTP_LAST = 7'h40;
	localparam int LOCK_WR_BIT = 0;
	localparam int LOCK_DOWN_BIT = 1;
	localparam logic [7:0] OP_FAST_READ = 8'h0B;
	localparam logic [7:0] OP_DUAL_READ = 8'h3B;
	localparam logic [7:0] OP_LOCK_READ = 8'hE8;
	localparam logic [7:0] OP_OTP_READ = 8'h4B;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_LEN = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_DATA = 8'h10;
	localparam int CTRL_START_BIT = 4;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int LEN_W = 3;
	localparam logic [2:0] MAX_LEN = 3'h4;
	typedef enum logic [1:0] {RD_FAST, RD_DUAL, RD_LOCK, RD_OTP} read_kind_t;
	// Opcode of each read kind
	function automatic logic [7:0] kindOpcode(input read_kind_t k);
		unique case (k)
			RD_FAST: kindOpcode = OP_FAST_READ;
			RD_DUAL: kindOpcode = OP_DUAL_READ;
			RD_LOCK: kindOpcode = OP_LOCK_READ;
			RD_OTP: kindOpcode = OP_OTP_READ;
		endcase
	endfunction : kindOpcode
endpackage : spi_flash_pkg

// ---- spi_flash_if.sv ----
// Link between the flash device end and the host controller end
`timescale 1ns/1ps
interface spi_flash_if;
	logic spiClk;
	logic csN;
	logic hostIo0;
	logic hostIo0OeN;
	logic devIo0;
	logic devIo0OeN;
	logic devIo1;
	logic devIo1OeN;
	logic io0;
	logic io1;
	// Wire levels, pulled high when nobody drives
	assign io0 = !hostIo0OeN ? hostIo0 : (!devIo0OeN ? devIo0 : 1'b1);
	assign io1 = !devIo1OeN ? devIo1 : 1'b1;
	modport device (input spiClk, input csN, input io0, output devIo0, output devIo0OeN, output devIo1,
		output devIo1OeN);
	modport host (output spiClk, output csN, output hostIo0, output hostIo0OeN, input io0, input io1);
endinterface : spi_flash_if

// ---- serial_flash_device.sv ----
// Flash device end: read instructions, lock bits and one-time area
`timescale 1ns/1ps
// Summary of operation
// RULE1 - Opcode, 24-bit address, dummy byte sampled rising
// RULE2 - Fast read shifts data on io_line_1, falling
// RULE3 - Dual read drives two lines per falling edge
// RULE4 - Address increments per byte, wraps to zero
// RULE5 - Top two address bits ignored
// RULE6 - Chip select high ends read, releases outputs
// RULE7 - Reads rejected while a write cycle runs
// RULE8 - Lock read returns sector lock bits on io_line_1
// RULE9 - Lock-down bit blocks lock changes until power-up
// RULE10 - Write-lock bit blocks writes within sector
// RULE11 - One-time area read with dummy, io_line_1 out
// RULE12 - One-time area address advances per byte
// RULE13 - One-time area sticks at sixty-fifth byte
// RULE14 - Host requests at most four bytes per read
// RULE15 - One-time area uses only low address bits
// RULE16 - Dual pairs: odd bit line 1, MSB first
// RULE17 - Data lines released outside output phase
module serial_flash_device import spi_flash_pkg::*; #(
	parameter int ADDR_W = MAX_ADDR_W,
	parameter logic [1:0] LOCK_INIT = 2'h0
) (
	// Link
	spi_flash_if.device link,
	// User side clock and power-up reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Erase, program or status write cycle in progress
	input wire logic writeBusy,
	// Memory write port
	input wire logic memWrEn,
	input wire logic memWrOtp,
	input wire logic [23:0] memWrAddr,
	input wire logic [7:0] memWrData,
	output logic memWrRefused,
	// Lock bit write port
	input wire logic lockWrEn,
	input wire logic [23:0] lockWrAddr,
	input wire logic [1:0] lockWrData,
	output logic lockWrRefused
);
	localparam int SECTORS = 2 ** (ADDR_W - SECTOR_SHIFT);

	initial begin
		if (ADDR_W > MAX_ADDR_W || ADDR_W <= SECTOR_SHIFT) begin
			$error("ADDR_W out of range");
		end
	end

	typedef enum {F_CMD, F_ADDR, F_DUMMY, F_DATA, F_IGNORE} frame_t;

	logic [7:0] flashMem [2 ** ADDR_W];
	logic [7:0] otpMem [OTP_BYTES];
	logic [1:0] lockMem [SECTORS];

	frame_t state_q;
	read_kind_t kind_q;
	logic [4:0] bitCnt_q;
	logic [6:0] cmdSh_q;
	logic [22:0] addrSh_q;
	logic [ADDR_W-1:0] startAddr_q;
	logic busyMeta_q;
	logic busySync_q;
	logic started_q;
	logic [2:0] slot_q;
	logic [7:0] sh_q;
	logic [ADDR_W-1:0] curAddr_q;
	logic drive0_q;
	logic drive1_q;
	logic [7:0] cmdWord;
	logic [23:0] addrWord;

	function automatic logic [ADDR_W-SECTOR_SHIFT-1:0] sectorOf(input logic [23:0] a);
		sectorOf = a[ADDR_W-1:SECTOR_SHIFT];
	endfunction : sectorOf

	function automatic logic [6:0] otpIndex(input logic [ADDR_W-1:0] a);
		otpIndex = (a[OTP_AW-1:0] > OTP_LAST) ? OTP_LAST : a[OTP_AW-1:0]; // [RULE15]
	endfunction : otpIndex

	function automatic logic [7:0] fetchByte(input read_kind_t k, input logic [ADDR_W-1:0] a);
		unique case (k)
			RD_LOCK: fetchByte = {6'h00, lockMem[a[ADDR_W-1:SECTOR_SHIFT]]}; // [RULE8]
			RD_OTP: fetchByte = otpMem[otpIndex(a)];
			default: fetchByte = flashMem[a];
		endcase
	endfunction : fetchByte

	function automatic logic [ADDR_W-1:0] nextAddr(input read_kind_t k, input logic [ADDR_W-1:0] a);
		unique case (k)
			RD_LOCK: nextAddr = a;
			RD_OTP: nextAddr = (otpIndex(a) == OTP_LAST) ? a : a + ADDR_W'(1); // [RULE12] [RULE13]
			default: nextAddr = a + ADDR_W'(1); // [RULE4]
		endcase
	endfunction : nextAddr

	// User side writes of memory and lock bits
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			for (int i = 0; i < SECTORS; i++) begin
				lockMem[i] <= LOCK_INIT;
			end
			lockWrRefused <= 1'b0;
		end else begin
			lockWrRefused <= 1'b0;
			if (lockWrEn) begin
				if (lockMem[sectorOf(lockWrAddr)][LOCK_DOWN_BIT]) begin
					lockWrRefused <= 1'b1; // [RULE9]
				end else begin
					lockMem[sectorOf(lockWrAddr)] <= lockWrData;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			memWrRefused <= 1'b0;
		end else begin
			memWrRefused <= 1'b0;
			if (memWrEn && memWrOtp) begin
				otpMem[otpIndex(memWrAddr[ADDR_W-1:0])] <= memWrData;
			end else if (memWrEn) begin
				if (lockMem[sectorOf(memWrAddr)][LOCK_WR_BIT]) begin
					memWrRefused <= 1'b1; // [RULE10]
				end else begin
					flashMem[memWrAddr[ADDR_W-1:0]] <= memWrData;
				end
			end
		end
	end

	// Write cycle flag into the link domain
	always_ff @(posedge link.spiClk or posedge link.csN) begin
		if (link.csN) begin
			busyMeta_q <= 1'b0;
			busySync_q <= 1'b0;
		end else begin
			busyMeta_q <= writeBusy;
			busySync_q <= busyMeta_q;
		end
	end

	assign cmdWord = {cmdSh_q, link.io0};
	assign addrWord = {addrSh_q, link.io0};

	// Instruction, address and dummy capture on rising edges
	always_ff @(posedge link.spiClk or posedge link.csN) begin
		if (link.csN) begin
			state_q <= F_CMD; // [RULE6]
			kind_q <= RD_FAST;
			bitCnt_q <= 5'h00;
			cmdSh_q <= 7'h00;
			addrSh_q <= 23'h000000;
			startAddr_q <= '0;
		end else begin
			bitCnt_q <= bitCnt_q + 5'h01;
			unique case (state_q)
				F_CMD: begin
					cmdSh_q <= cmdWord[6:0]; // [RULE1]
					if (bitCnt_q == 5'(CMD_BITS - 1)) begin
						bitCnt_q <= 5'h00;
						state_q <= F_ADDR;
						if (busySync_q) begin
							state_q <= F_IGNORE; // [RULE7]
						end else if (cmdWord == OP_FAST_READ) begin
							kind_q <= RD_FAST;
						end else if (cmdWord == OP_DUAL_READ) begin
							kind_q <= RD_DUAL;
						end else if (cmdWord == OP_LOCK_READ) begin
							kind_q <= RD_LOCK;
						end else if (cmdWord == OP_OTP_READ) begin
							kind_q <= RD_OTP;
						end else begin
							state_q <= F_IGNORE;
						end
					end
				end
				F_ADDR: begin
					addrSh_q <= addrWord[22:0]; // [RULE1]
					if (bitCnt_q == 5'(ADDR_BITS - 1)) begin
						bitCnt_q <= 5'h00;
						startAddr_q <= addrWord[ADDR_W-1:0]; // [RULE5]
						state_q <= (kind_q == RD_LOCK) ? F_DATA : F_DUMMY; // [RULE8]
					end
				end
				F_DUMMY: begin
					if (bitCnt_q == 5'(DUMMY_BITS - 1)) begin
						bitCnt_q <= 5'h00;
						state_q <= F_DATA; // [RULE11]
					end
				end
				F_DATA, F_IGNORE: begin
					bitCnt_q <= 5'h00;
				end
			endcase
		end
	end

	// Output shifting on falling edges
	always_ff @(negedge link.spiClk or posedge link.csN) begin
		if (link.csN) begin
			started_q <= 1'b0;
			slot_q <= 3'h0;
			sh_q <= 8'h00;
			curAddr_q <= '0;
			drive0_q <= 1'b0; // [RULE6] [RULE17]
			drive1_q <= 1'b0;
		end else if (state_q == F_DATA) begin
			started_q <= 1'b1;
			drive1_q <= 1'b1; // [RULE2]
			drive0_q <= (kind_q == RD_DUAL); // [RULE3]
			if (!started_q) begin
				sh_q <= fetchByte(kind_q, startAddr_q);
				curAddr_q <= startAddr_q;
				slot_q <= (kind_q == RD_DUAL) ? 3'h3 : 3'h7;
			end else if (slot_q == 3'h0) begin
				sh_q <= fetchByte(kind_q, nextAddr(kind_q, curAddr_q));
				curAddr_q <= nextAddr(kind_q, curAddr_q);
				slot_q <= (kind_q == RD_DUAL) ? 3'h3 : 3'h7;
			end else begin
				sh_q <= (kind_q == RD_DUAL) ? {sh_q[5:0], 2'b00} : {sh_q[6:0], 1'b0}; // [RULE16]
				slot_q <= slot_q - 3'h1;
			end
		end
	end

	assign link.devIo1 = sh_q[7]; // [RULE16]
	assign link.devIo0 = sh_q[6];
	assign link.devIo1OeN = ~drive1_q; // [RULE17]
	assign link.devIo0OeN = ~drive0_q;
endmodule : serial_flash_device

// ---- serial_flash_host.sv ----
// Host controller end: APB registers driving read instructions on the link
`timescale 1ns/1ps
module serial_flash_host import spi_flash_pkg::*; #(
	parameter int DIV_HALF = 2
) (
	// System
	input wire logic clk_sys,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link
	spi_flash_if.host link
);
	initial begin
		if (DIV_HALF < 2 || DIV_HALF > 255) begin
			$error("DIV_HALF out of range");
		end
	end

	typedef enum {H_IDLE, H_LEAD, H_RUN, H_TAIL} host_t;

	host_t state_q;
	read_kind_t kind_q;
	logic [23:0] addr_q;
	logic [2:0] len_q;
	logic done_q;
	logic [31:0] data_q;
	logic [31:0] rx_q;
	logic [39:0] tx_q;
	logic [7:0] div_q;
	logic [6:0] bit_q;
	logic [6:0] outBits_q;
	logic [6:0] total_q;
	logic sck_q;
	logic csN_q;
	logic io0OeN_q;
	logic in0Meta_q;
	logic in0Sync_q;
	logic in1Meta_q;
	logic in1Sync_q;
	logic setup;
	logic wrAccess;
	logic mapped;
	logic start;
	logic halfDone;
	logic finishing;
	read_kind_t newKind;

	assign setup = psel && !penable;
	assign wrAccess = psel && penable && pwrite;
	assign mapped = paddr == REG_CTRL || paddr == REG_ADDR || paddr == REG_LEN || paddr == REG_STATUS
		|| paddr == REG_DATA;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign start = wrAccess && paddr == REG_CTRL && pwdata[CTRL_START_BIT] && state_q == H_IDLE
		&& len_q != 3'h0;
	// Kind written together with the start bit serves the frame it starts
	assign newKind = read_kind_t'(pwdata[1:0]);
	assign halfDone = div_q == 8'(DIV_HALF - 1);
	assign finishing = state_q == H_TAIL && halfDone;

	// Register writes
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			kind_q <= RD_FAST;
			addr_q <= 24'h000000;
			len_q <= 3'h1;
		end else if (wrAccess && state_q == H_IDLE) begin
			if (paddr == REG_CTRL) begin
				kind_q <= newKind;
			end
			if (paddr == REG_ADDR) begin
				addr_q <= pwdata[23:0];
			end
			if (paddr == REG_LEN) begin
				len_q <= (pwdata[2:0] > MAX_LEN) ? MAX_LEN : pwdata[2:0]; // [RULE14]
			end
		end
	end

	// Read data captured in the setup cycle
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			prdata <= 32'h00000000;
		end else if (setup) begin
			unique case (paddr)
				REG_CTRL: prdata <= {30'h00000000, kind_q};
				REG_ADDR: prdata <= {8'h00, addr_q};
				REG_LEN: prdata <= {29'h00000000, len_q};
				REG_STATUS: prdata <= {30'h00000000, done_q, state_q != H_IDLE};
				REG_DATA: prdata <= data_q;
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	// Done flag: end of frame wins over the clear by a new start
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			done_q <= 1'b0;
		end else if (finishing) begin
			done_q <= 1'b1;
		end else if (start) begin
			done_q <= 1'b0;
		end
	end

	// Returned lines into the system domain
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			in0Meta_q <= 1'b0;
			in0Sync_q <= 1'b0;
			in1Meta_q <= 1'b0;
			in1Sync_q <= 1'b0;
		end else begin
			in0Meta_q <= link.io0;
			in0Sync_q <= in0Meta_q;
			in1Meta_q <= link.io1;
			in1Sync_q <= in1Meta_q;
		end
	end

	// Frame sequencer and clock divider
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_q <= H_IDLE;
			csN_q <= 1'b1;
			sck_q <= 1'b0;
			div_q <= 8'h00;
			bit_q <= 7'h00;
			outBits_q <= 7'h00;
			total_q <= 7'h00;
			tx_q <= 40'h0000000000;
			rx_q <= 32'h00000000;
			data_q <= 32'h00000000;
			io0OeN_q <= 1'b0;
		end else begin
			div_q <= halfDone ? 8'h00 : div_q + 8'h01;
			unique case (state_q)
				H_IDLE: begin
					div_q <= 8'h00;
					if (start) begin
						state_q <= H_LEAD;
						csN_q <= 1'b0;
						bit_q <= 7'h00;
						rx_q <= 32'h00000000;
						tx_q <= {kindOpcode(newKind), addr_q, 8'h00}; // [RULE1]
						outBits_q <= (newKind == RD_LOCK) ? 7'(CMD_BITS + ADDR_BITS) // [RULE8]
							: 7'(CMD_BITS + ADDR_BITS + DUMMY_BITS); // [RULE11]
						total_q <= (newKind == RD_LOCK ? 7'(CMD_BITS + ADDR_BITS) : 7'(CMD_BITS + ADDR_BITS
							+ DUMMY_BITS)) + (newKind == RD_DUAL ? {2'b00, len_q, 2'b00} : {1'b0, len_q, 3'b000});
					end
				end
				H_LEAD: begin
					if (halfDone) begin
						state_q <= H_RUN;
						sck_q <= 1'b1;
					end
				end
				H_RUN: begin
					if (halfDone && !sck_q) begin
						sck_q <= 1'b1;
					end else if (halfDone) begin
						sck_q <= 1'b0;
						if (bit_q >= outBits_q) begin
							rx_q <= (kind_q == RD_DUAL) ? {rx_q[29:0], in1Sync_q, in0Sync_q} // [RULE3]
								: {rx_q[30:0], in1Sync_q}; // [RULE2]
						end
						if (bit_q == total_q - 7'h01) begin
							state_q <= H_TAIL;
						end else begin
							bit_q <= bit_q + 7'h01;
							tx_q <= {tx_q[38:0], 1'b0};
							if (kind_q == RD_DUAL && bit_q + 7'h01 >= outBits_q) begin
								io0OeN_q <= 1'b1;
							end
						end
					end
				end
				H_TAIL: begin
					if (halfDone) begin
						state_q <= H_IDLE;
						csN_q <= 1'b1; // [RULE6]
						io0OeN_q <= 1'b0;
						data_q <= rx_q;
					end
				end
			endcase
		end
	end

	assign link.spiClk = sck_q;
	assign link.csN = csN_q;
	assign link.hostIo0 = tx_q[39];
	assign link.hostIo0OeN = io0OeN_q;
endmodule : serial_flash_host

// ---- serial_flash_props.sv ----
// Link checker for the serial flash read link
`timescale 1ns/1ps
module serial_flash_props import spi_flash_pkg::*; (
	// Clocks and resets
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic spiClk,
	input wire logic csN,
	// Link lines
	input wire logic hostIo0OeN,
	input wire logic io0,
	input wire logic devIo0,
	input wire logic devIo0OeN,
	input wire logic devIo1,
	input wire logic devIo1OeN,
	// Device side
	input wire logic writeBusy
);
	logic [5:0] bitCnt_q;
	logic [7:0] op_q;
	// Rising edges seen in this frame
	always_ff @(posedge spiClk or posedge csN) begin
		if (csN) begin
			bitCnt_q <= 6'h00;
		end else if (bitCnt_q != 6'h3F) begin
			bitCnt_q <= bitCnt_q + 6'h01;
		end
	end
	// Opcode of this frame
	always_ff @(posedge spiClk or posedge csN) begin
		if (csN) begin
			op_q <= 8'h00;
		end else if (bitCnt_q < 6'h08) begin
			op_q <= {op_q[6:0], io0};
		end
	end
	sequence dualDrive;
		!devIo1OeN && !devIo0OeN && hostIo0OeN;
	endsequence
	sequence singleDrive;
		!devIo1OeN && devIo0OeN;
	endsequence
	chk_release_deselect: assert property (@(posedge clk_sys) disable iff (sys_rst)
		csN |-> devIo1OeN && devIo0OeN) else $error("device drives while deselected");
	chk_no_contention: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!(!hostIo0OeN && !devIo0OeN)) else $error("both ends drive io0");
	chk_hold_high_phase: assert property (@(posedge clk_sys) disable iff (sys_rst || csN)
		spiClk && $past(spiClk) |-> $stable({devIo1, devIo0})) else $error("output changed while clock high");
	chk_host_cmd_drive: assert property (@(negedge spiClk) disable iff (csN)
		bitCnt_q < 6'h28 |-> !hostIo0OeN) else $error("host released io0 early");
	chk_quiet_input_phase: assert property (@(negedge spiClk) disable iff (csN)
		bitCnt_q <= 6'h20 || (op_q != OP_LOCK_READ && bitCnt_q <= 6'h28) |-> devIo1OeN && devIo0OeN)
		else $error("device drives before output phase");
	chk_single_line: assert property (@(negedge spiClk) disable iff (csN)
		bitCnt_q > 6'h28 && op_q != OP_DUAL_READ && !writeBusy |-> singleDrive) else $error("single line read wrong");
	chk_dual_lines: assert property (@(negedge spiClk) disable iff (csN)
		bitCnt_q > 6'h28 && op_q == OP_DUAL_READ && !writeBusy |-> dualDrive) else $error("dual read wrong");
	chk_busy_reject: assert property (@(negedge spiClk) disable iff (csN)
		writeBusy |-> devIo1OeN && devIo0OeN) else $error("read served during write cycle");
endmodule : serial_flash_props

// ---- tb_top.sv ----
// Self-checking bench for the serial flash host and device ends
`timescale 1ns/1ps
module tb_top import spi_flash_pkg::*; ();
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic writeBusy = 1'b0, memWrEn = 1'b0, memWrOtp = 1'b0, lockWrEn = 1'b0, memWrRefused, lockWrRefused;
	logic [23:0] memWrAddr = 24'h0, lockWrAddr = 24'h0;
	logic [7:0] memWrData = 8'h00;
	logic [1:0] lockWrData = 2'h0;
	int nFail = 0, nTests = 0, cyc = 0;
	spi_flash_if lnk ();
	serial_flash_host #(.DIV_HALF(2)) i_serial_flash_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(lnk.host));
	serial_flash_device #(.ADDR_W(17), .LOCK_INIT(2'h0)) i_serial_flash_device (.link(lnk.device),
		.clk_sys(clk_sys), .sys_rst(sys_rst), .writeBusy(writeBusy), .memWrEn(memWrEn), .memWrOtp(memWrOtp),
		.memWrAddr(memWrAddr), .memWrData(memWrData), .memWrRefused(memWrRefused), .lockWrEn(lockWrEn),
		.lockWrAddr(lockWrAddr), .lockWrData(lockWrData), .lockWrRefused(lockWrRefused));
	serial_flash_props chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .spiClk(lnk.spiClk), .csN(lnk.csN),
		.hostIo0OeN(lnk.hostIo0OeN), .io0(lnk.io0), .devIo0(lnk.devIo0), .devIo0OeN(lnk.devIo0OeN),
		.devIo1(lnk.devIo1), .devIo1OeN(lnk.devIo1OeN), .writeBusy(writeBusy));
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			nFail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic final_report();
		$display("checks %0d mismatches %0d", nTests, nFail);
		if (nFail == 0 && nTests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic err);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Device side memory or lock write, returns the refusal pulse
	task automatic poke(input logic lock, input logic otp, input logic [23:0] a, input logic [7:0] d,
		output logic refused);
		@(posedge clk_sys);
		memWrEn <= !lock;
		lockWrEn <= lock;
		memWrOtp <= otp;
		memWrAddr <= a;
		lockWrAddr <= a;
		memWrData <= d;
		lockWrData <= d[1:0];
		@(posedge clk_sys);
		memWrEn <= 1'b0;
		lockWrEn <= 1'b0;
		@(posedge clk_sys);
		refused = lock ? lockWrRefused : memWrRefused;
	endtask : poke
	task automatic rd(input read_kind_t k, input logic [23:0] a, input logic [2:0] n, output logic [31:0] q);
		logic [31:0] s;
		logic e;
		apb(1'b1, REG_ADDR, {8'h00, a}, s, e);
		apb(1'b1, REG_LEN, {29'h0, n}, s, e);
		apb(1'b1, REG_CTRL, {27'h0, 1'b1, 2'h0, k}, s, e);
		s = 32'h0;
		while (s[STAT_DONE_BIT] !== 1'b1) apb(1'b0, REG_STATUS, 32'h0, s, e);
		apb(1'b0, REG_DATA, 32'h0, q, e);
	endtask : rd
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			nFail++;
			final_report();
		end
	end
	initial begin
		logic [31:0] q;
		logic e;
		logic r;
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			poke(1'b0, 1'b0, 24'((24'h1FFFE + i) & 24'h1FFFF), 8'(8'hA0 + i), r);
			poke(1'b0, 1'b1, 24'(24'h3D + i), 8'(8'h50 + i), r);
		end
		apb(1'b0, 8'h20, 32'h0, q, e);
		check("unmapped error", {31'h0, e}, 32'h1);
		check("unmapped data", q, 32'h0);
		apb(1'b1, REG_ADDR, 32'h00ABCDEF, q, e);
		apb(1'b0, REG_ADDR, 32'h0, q, e);
		check("address register", q, 32'h00ABCDEF);
		rd(RD_FAST, 24'hFFFFFE, 3'h4, q);
		check("fast read wrap", q, 32'hA0A1A2A3);
		rd(RD_DUAL, 24'hC1FFFE, 3'h4, q);
		check("dual read wrap", q, 32'hA0A1A2A3);
		rd(RD_OTP, 24'hFFFFBF, 3'h4, q);
		check("one-time stick", q, 32'h52535353);
		rd(RD_LOCK, 24'h010000, 3'h2, q);
		check("lock initial", q, 32'h0);
		poke(1'b1, 1'b0, 24'h01ABCD, 8'h01, r);
		check("lock set", {31'h0, r}, 32'h0);
		rd(RD_LOCK, 24'h01FFFF, 3'h2, q);
		check("lock sector one", q, 32'h0101);
		rd(RD_LOCK, 24'h000000, 3'h1, q);
		check("lock sector zero", q, 32'h0);
		poke(1'b0, 1'b0, 24'h01FFFF, 8'h77, r);
		check("locked write", {31'h0, r}, 32'h1);
		poke(1'b0, 1'b0, 24'h000000, 8'h66, r);
		check("open write", {31'h0, r}, 32'h0);
		rd(RD_FAST, 24'h01FFFF, 3'h2, q);
		check("locked content", q, 32'hA166);
		poke(1'b1, 1'b0, 24'h010000, 8'h03, r);
		poke(1'b1, 1'b0, 24'h010000, 8'h00, r);
		check("lock down refusal", {31'h0, r}, 32'h1);
		rd(RD_LOCK, 24'h010000, 3'h1, q);
		check("lock down kept", q, 32'h03);
		writeBusy <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			rd(read_kind_t'(k), 24'h000000, 3'h1, q);
			check("busy reject", q, 32'hFF);
		end
		writeBusy <= 1'b0;
		apb(1'b0, REG_CTRL, 32'h0, q, e);
		check("control readback", q, 32'h3);
		apb(1'b0, REG_STATUS, 32'h0, q, e);
		check("status idle done", q, 32'h2);
		apb(1'b1, REG_LEN, 32'h7, q, e);
		apb(1'b0, REG_LEN, 32'h0, q, e);
		check("length clamp", q, 32'h4);
		final_report();
	end
endmodule : tb_top
